/* File: inc/icw_pkg.sv */
package icw_pkg;

  // Identify word indices served by this block.
  localparam logic [7:0] ICW_W63 = 8'h3F;
  localparam logic [7:0] ICW_W64 = 8'h40;
  localparam logic [7:0] ICW_W80 = 8'h50;
  localparam logic [7:0] ICW_W82 = 8'h52;
  localparam logic [7:0] ICW_W83 = 8'h53;
  localparam logic [7:0] ICW_W85 = 8'h55;
  localparam logic [7:0] ICW_W86 = 8'h56;
  localparam logic [7:0] ICW_W88 = 8'h58;
  localparam logic [7:0] ICW_W89 = 8'h59;
  localparam logic [7:0] ICW_W93 = 8'h5D;

  // Fixed word contents.
  localparam logic [15:0] ICW_W64_VAL = 16'h0003;
  localparam logic [15:0] ICW_W80_VAL = 16'h003E;
  localparam logic [15:0] ICW_W82_VAL = 16'h346B;
  localparam logic [15:0] ICW_W83_VAL = 16'h4108;
  localparam logic [15:0] ICW_ZERO = 16'h0000;

  // Supported transfer modes, thermometer coded in the low bits.
  localparam logic [2:0] ICW_MDMA_SUP = 3'h7;
  localparam logic [5:0] ICW_UDMA_SUP = 6'h3F;
  localparam int ICW_SEL_LSB = 8;

  // Enable bit positions of words 85 and 86.
  localparam int ICW_W85_RDBUF = 13;
  localparam int ICW_W85_WRBUF = 12;
  localparam int ICW_W85_HPA = 10;
  localparam int ICW_W85_LOOK = 6;
  localparam int ICW_W85_WCACHE = 5;
  localparam int ICW_W85_PM = 3;
  localparam int ICW_W85_SEC = 1;
  localparam int ICW_W85_SMART = 0;
  localparam int ICW_W86_AAM = 9;
  localparam int ICW_W86_MAXPW = 8;
  localparam int ICW_W86_APM = 3;

  // Security erase times for the capacity variants.
  localparam logic [15:0] ICW_ERASE_8MIN = 16'h0004;
  localparam logic [15:0] ICW_ERASE_16MIN = 16'h0008;
  localparam logic [15:0] ICW_ERASE_32MIN = 16'h0010;

  // Word 93 layout.
  localparam logic [1:0] ICW_W93_TOP = 2'h1;
  localparam logic [4:0] ICW_W93_D0_HI = 5'h00;
  localparam logic [7:0] ICW_W93_D1_LO = 8'h00;

  typedef enum logic [1:0] {
    ICW_CAP_SMALL = 2'b00,
    ICW_CAP_MID = 2'b01,
    ICW_CAP_LARGE = 2'b10,
    ICW_CAP_NONE = 2'b11
  } icw_cap_t;

  typedef enum logic [1:0] {
    ICW_HOW_RSVD = 2'b00,
    ICW_HOW_JUMPER = 2'b01,
    ICW_HOW_CSEL = 2'b10,
    ICW_HOW_OTHER = 2'b11
  } icw_how_t;

endpackage

/* File: rtl/icw_onehot.sv */
module icw_onehot #(
  parameter int N = 3,
  parameter int W = 2
) (
  // Selected mode
  input wire logic i_active,
  input wire logic [W-1:0] i_mode,
  // One bit per mode
  output logic [N-1:0] o_onehot
);

  // Codes beyond the last mode select nothing.
  always_comb begin
    o_onehot = '0;
    for (int i = 0; i < N; i++) begin
      if (i_active && (i_mode == W'(i))) begin
        o_onehot[i] = 1'b1;
      end
    end
  end

endmodule

/* File: rtl/icw_sync.sv */
module icw_sync
  import icw_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Pin side and filtered level
  input wire logic i_pin,
  output logic o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } icw_sync_t;

  icw_sync_t q;
  icw_sync_t d;

  // A change is accepted only once the second and third stage agree.
  always_comb begin
    d = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.level;

endmodule

/* File: rtl/icw_top.sv */
module icw_top
  import icw_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Hardware reset in progress and straps, from pins
  input wire logic i_hw_reset,
  input wire logic i_cable_detect,
  input wire logic i_dev1_cfg,
  // Reset results from the drive's own reset logic
  input wire logic i_dev1_pdiag,
  input wire logic [1:0] i_devnum_how,
  input wire logic [7:0] i_dev0_result,
  // Current transfer mode selection
  input wire logic i_mdma_active,
  input wire logic [1:0] i_mdma_mode,
  input wire logic i_udma_active,
  input wire logic [2:0] i_udma_mode,
  // Feature enable levels
  input wire logic i_rdbuf_en,
  input wire logic i_wrbuf_en,
  input wire logic i_hpa_en,
  input wire logic i_lookahead_en,
  input wire logic i_wcache_en,
  input wire logic i_pm_en,
  input wire logic i_sec_en,
  input wire logic i_smart_en,
  input wire logic i_aam_en,
  input wire logic i_maxpw_en,
  input wire logic i_apm_en,
  // Capacity variant
  input wire logic [1:0] i_capacity,
  // Word read port
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_word,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_rd_hit
);

  typedef struct packed {
    logic [2:0] mdma_sel;
    logic [5:0] udma_sel;
    logic [15:0] w85;
    logic [15:0] w86;
    logic [15:0] w89;
    logic cable;
    logic [12:0] w93_lo;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_hit;
  } icw_state_t;

  icw_state_t q;
  icw_state_t d;

  logic hwrst_s;
  logic cable_s;
  logic dev1_s;
  logic [2:0] mdma_oh;
  logic [5:0] udma_oh;
  logic [12:0] w93_capture;
  logic [15:0] w63;
  logic [15:0] w88;
  logic [15:0] w93;
  icw_how_t how;

  // Pins from outside the clock domain pass the three-stage filter.
  icw_sync u_sync_rst (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_hw_reset),
    .o_level(hwrst_s)
  );

  icw_sync u_sync_cable (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_cable_detect),
    .o_level(cable_s)
  );

  icw_sync u_sync_dev1 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_dev1_cfg),
    .o_level(dev1_s)
  );

  icw_onehot #(
    .N(3),
    .W(2)
  ) u_mdma_dec (
    .i_active(i_mdma_active),
    .i_mode(i_mdma_mode),
    .o_onehot(mdma_oh)
  );

  icw_onehot #(
    .N(6),
    .W(3)
  ) u_udma_dec (
    .i_active(i_udma_active),
    .i_mode(i_udma_mode),
    .o_onehot(udma_oh)
  );

  // The reserved method code is never reported; an unknown method is.
  always_comb begin
    how = icw_how_t'(i_devnum_how);
    if (how == ICW_HOW_RSVD) begin
      how = ICW_HOW_OTHER;
    end
  end

  // Reset result as it would be recorded this cycle.
  always_comb begin
    if (dev1_s) begin
      w93_capture = {1'b0, i_dev1_pdiag, how, 1'b1,
                     ICW_W93_D1_LO};
    end else begin
      w93_capture = {ICW_W93_D0_HI, i_dev0_result};
    end
  end

  // Assembled words; reserved fields are tied to zero.
  always_comb begin
    w63 = ICW_ZERO;
    w63[ICW_SEL_LSB +: 3] = q.mdma_sel;
    w63[2:0] = ICW_MDMA_SUP;
    w88 = ICW_ZERO;
    w88[ICW_SEL_LSB +: 6] = q.udma_sel;
    w88[5:0] = ICW_UDMA_SUP;
    w93 = {ICW_W93_TOP, q.cable, q.w93_lo};
  end

  always_comb begin
    d = q;
    d.mdma_sel = mdma_oh;
    d.udma_sel = udma_oh;

    d.w85 = ICW_ZERO;
    d.w85[ICW_W85_RDBUF] = i_rdbuf_en;
    d.w85[ICW_W85_WRBUF] = i_wrbuf_en;
    d.w85[ICW_W85_HPA] = i_hpa_en;
    d.w85[ICW_W85_LOOK] = i_lookahead_en;
    d.w85[ICW_W85_WCACHE] = i_wcache_en;
    d.w85[ICW_W85_PM] = i_pm_en;
    d.w85[ICW_W85_SEC] = i_sec_en;
    d.w85[ICW_W85_SMART] = i_smart_en;

    d.w86 = ICW_ZERO;
    d.w86[ICW_W86_AAM] = i_aam_en;
    d.w86[ICW_W86_MAXPW] = i_maxpw_en;
    d.w86[ICW_W86_APM] = i_apm_en;

    unique case (icw_cap_t'(i_capacity))
      ICW_CAP_SMALL: d.w89 = ICW_ERASE_8MIN;
      ICW_CAP_MID: d.w89 = ICW_ERASE_16MIN;
      ICW_CAP_LARGE: d.w89 = ICW_ERASE_32MIN;
      ICW_CAP_NONE: d.w89 = ICW_ZERO;
    endcase

    // The result word is frozen outside a hardware reset, so a host that
    // reads it later sees what the last reset found, not the live pins.
    if (hwrst_s) begin
      d.w93_lo = w93_capture;
      d.cable = cable_s;
    end

    d.rd_valid = i_rd_en;
    d.rd_hit = 1'b0;
    d.rd_data = ICW_ZERO;
    if (i_rd_en) begin
      d.rd_hit = 1'b1;
      unique case (i_rd_word)
        ICW_W63: d.rd_data = w63;
        ICW_W64: d.rd_data = ICW_W64_VAL;
        ICW_W80: d.rd_data = ICW_W80_VAL;
        ICW_W82: d.rd_data = ICW_W82_VAL;
        ICW_W83: d.rd_data = ICW_W83_VAL;
        ICW_W85: d.rd_data = q.w85;
        ICW_W86: d.rd_data = q.w86;
        ICW_W88: d.rd_data = w88;
        ICW_W89: d.rd_data = q.w89;
        ICW_W93: d.rd_data = w93;
        default: begin
          d.rd_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rd_data = q.rd_data;
  assign o_rd_valid = q.rd_valid;
  assign o_rd_hit = q.rd_hit;

endmodule

/* File: test/icw_host.sv */
module icw_host (
  // Clock
  input wire logic i_ref_clk,
  // Read request
  output logic o_rd_en,
  output logic [7:0] o_rd_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rd_en = 1'b0;
    o_rd_word = 8'hFF;
  end
  // A released index is inverted so a stale value never looks valid.
  task automatic rd(input logic [7:0] w);
    @(negedge i_ref_clk);
    o_rd_en = 1'b1;
    o_rd_word = w;
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    o_rd_word = ~w;
  endtask
endmodule

/* File: test/icw_top_asserts.sv */
module icw_chk
  import icw_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Read port
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_word,
  input wire logic [15:0] o_rd_data,
  input wire logic o_rd_hit,
  // Transfer mode selection
  input wire logic i_mdma_active,
  input wire logic [1:0] i_mdma_mode,
  input wire logic i_udma_active,
  input wire logic [2:0] i_udma_mode
);
  logic [7:0] rw;
  logic [2:0] mdma_exp;
  logic [5:0] udma_exp;
  // Index 0 is never served, so an idle port can stand for it.
  assign rw = i_rd_en ? i_rd_word : 8'h00;
  // Selected-mode flags the host should see; codes past the last mode
  // select nothing.
  assign mdma_exp = (i_mdma_active && i_mdma_mode != 2'h3) ?
    (3'h1 << i_mdma_mode) : 3'h0;
  assign udma_exp = (i_udma_active && i_udma_mode < 3'h6) ?
    (6'h01 << i_udma_mode) : 6'h00;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_w63; rw == ICW_W63 |=> o_rd_data[7:0] == 8'h07
    && o_rd_data[15:11] == 5'h00; endproperty
  a_w63: assert property (p_w63) else $error("w63");
  property p_w64; rw == ICW_W64 |=> o_rd_data == 16'h0003; endproperty
  a_w64: assert property (p_w64) else $error("w64");
  property p_w82; rw == ICW_W82 |=> o_rd_hit && o_rd_data == 16'h346B;
  endproperty
  a_w82: assert property (p_w82) else $error("w82");
  property p_w83; rw == ICW_W83 |=> o_rd_data == 16'h4108; endproperty
  a_w83: assert property (p_w83) else $error("w83");
  property p_w85; rw == ICW_W85 |=> (o_rd_data & 16'hCB94) == 16'h0000;
  endproperty
  a_w85: assert property (p_w85) else $error("w85");
  property p_w86; rw == ICW_W86 |=> (o_rd_data & 16'hFCF7) == 16'h0000;
  endproperty
  a_w86: assert property (p_w86) else $error("w86");
  property p_w88; rw == ICW_W88 |=> o_rd_data[7:0] == 8'h3F
    && o_rd_data[15:14] == 2'h0; endproperty
  a_w88: assert property (p_w88) else $error("w88");
  property p_w93; rw == ICW_W93 |=> o_rd_data[15:14] == 2'h1; endproperty
  a_w93: assert property (p_w93) else $error("w93");
  // The mode is registered one edge before the read that reports it.
  property p_mdma_sel; rw == ICW_W63 |=>
    o_rd_data[10:8] == $past(mdma_exp, 2); endproperty
  a_mdma_sel: assert property (p_mdma_sel) else $error("w63 sel");
  property p_udma_sel; rw == ICW_W88 |=>
    o_rd_data[13:8] == $past(udma_exp, 2); endproperty
  a_udma_sel: assert property (p_udma_sel) else $error("w88 sel");
endmodule
bind icw_top icw_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rd_en(i_rd_en),
  .i_rd_word(i_rd_word), .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit),
  .i_mdma_active(i_mdma_active), .i_mdma_mode(i_mdma_mode),
  .i_udma_active(i_udma_active), .i_udma_mode(i_udma_mode)
);

/* File: test/test_identify_capability_words.sv */
module test_identify_capability_words;
  timeunit 1ns;
  timeprecision 1ps;
  import icw_pkg::*;
  logic clk, rst_n, hw, cab, d1, pd, ma, ua, rd_en, vld, hit;
  logic [1:0] how, mm, cap;
  logic [2:0] um;
  logic [7:0] d0, rw;
  logic [10:0] en;
  logic [15:0] data;
  int failures, total_checks;

  icw_top u_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_hw_reset(hw),
    .i_cable_detect(cab), .i_dev1_cfg(d1), .i_dev1_pdiag(pd),
    .i_devnum_how(how), .i_dev0_result(d0), .i_mdma_active(ma),
    .i_mdma_mode(mm), .i_udma_active(ua), .i_udma_mode(um),
    .i_rdbuf_en(en[10]), .i_wrbuf_en(en[9]), .i_hpa_en(en[8]),
    .i_lookahead_en(en[7]), .i_wcache_en(en[6]), .i_pm_en(en[5]),
    .i_sec_en(en[4]), .i_smart_en(en[3]), .i_aam_en(en[2]),
    .i_maxpw_en(en[1]), .i_apm_en(en[0]), .i_capacity(cap),
    .i_rd_en(rd_en), .i_rd_word(rw), .o_rd_data(data),
    .o_rd_valid(vld), .o_rd_hit(hit)
  );
  icw_host u_host (.i_ref_clk(clk), .o_rd_en(rd_en), .o_rd_word(rw));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] w, input logic [17:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch word %0d expected %h seen %h", w, e, g);
    end
  endtask

  // Valid, hit and data are judged together in the answer cycle.
  task automatic rdc(input logic [7:0] w, input logic [15:0] e,
                     input logic h);
    u_host.rd(w);
    chk(w, {1'b1, h, e}, {vld, hit, data});
  endtask

  task automatic hwr();
    repeat (6) @(negedge clk);
    hw = 1'b1;
    repeat (10) @(negedge clk);
    hw = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n, hw, cab, d1, pd, ma, ua} = 7'h00;
    {how, mm, cap, um} = 9'h000;
    {d0, en} = 19'h00000;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rdc(ICW_W64, 16'h0003, 1'b1);
    rdc(ICW_W80, 16'h003E, 1'b1);
    rdc(ICW_W82, 16'h346B, 1'b1);
    rdc(ICW_W83, 16'h4108, 1'b1);
    rdc(8'h00, 16'h0000, 1'b0);
    $display("fixed words done");
    ma = 1'b1;
    for (int m = 0; m < 4; m++) begin
      mm = 2'(m);
      rdc(ICW_W63, {5'h00, 3'(m < 3 ? 1 << m : 0), 8'h07}, 1'b1);
    end
    ma = 1'b0;
    mm = 2'h2;
    rdc(ICW_W63, 16'h0007, 1'b1);
    ua = 1'b1;
    for (int u = 0; u < 7; u++) begin
      um = 3'(u);
      rdc(ICW_W88, {2'h0, 6'(u < 6 ? 1 << u : 0), 8'h3F}, 1'b1);
    end
    ua = 1'b0;
    um = 3'h5;
    rdc(ICW_W88, 16'h003F, 1'b1);
    $display("modes done");
    for (int i = 0; i < 2; i++) begin
      en = i ? 11'h2AA : 11'h555;
      rdc(ICW_W85, i ? 16'h1049 : 16'h2422, 1'b1);
      rdc(ICW_W86, i ? 16'h0100 : 16'h0208, 1'b1);
    end
    for (int c = 0; c < 4; c++) begin
      cap = 2'(c);
      rdc(ICW_W89, c < 3 ? 16'(4 << c) : 16'h0000, 1'b1);
    end
    $display("enables done");
    {cab, pd, how, d0} = 12'hEA5;
    hwr();
    rdc(ICW_W93, 16'h60A5, 1'b1);
    {cab, d1, d0} = 10'h13C;
    repeat (8) @(negedge clk);
    rdc(ICW_W93, 16'h60A5, 1'b1);
    hwr();
    rdc(ICW_W93, 16'h4D00, 1'b1);
    {cab, pd, how} = 4'h9;
    hwr();
    rdc(ICW_W93, 16'h6300, 1'b1);
    {pd, how} = 3'h7;
    hwr();
    rdc(ICW_W93, 16'h6F00, 1'b1);
    {pd, how} = 3'h0;
    hwr();
    rdc(ICW_W93, 16'h6700, 1'b1);
    $display("reset result done");
    print_verdict();
  end
endmodule
